// ---- pwd_top.sv ----
// dual-output pwm / sigma-delta dac with an ahb-lite register slave
// What this block does
// - disabled mode: no waveform, pins left free
// - single mode period from period pair
// - single mode duty from duty pair
// - twin 8-bit: shared period, period low byte
// - twin 8-bit: out a low at duty-low match
// - twin 8-bit: out b set/clear by high bytes
// - twin 16-bit: counter runs full 16 bits
// - twin 16-bit: out a high below duty a
// - twin 16-bit: out b high below second duty
// - twin 16-bit: each high on rollover unless its duty is zero
// - nrz dac: exactly code highs per 65536
// - nrz dac: highs spread evenly
// - dual 8-bit: own period for each output
// - dual 8-bit: duties from duty pair bytes
// - dual 8-bit: shared source and divider
// - rz dac: each high is half-clock pulse, except at divide 1
// - decode three-bit mode field
// - control write clears the counter
// - 16-bit modes: low byte held until high byte write, then applied at cycle end
// - selectable source, divide 1/4/16/64
//
// The register addresses and the AHB-Lite slave port were chosen for this implementation.
module pwd_top (
  input wire logic i_clock,
  input wire logic i_resetn,
  input wire logic i_hsel,
  input wire logic [7:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  input wire logic i_xtal_tick,
  input wire logic i_external_count_clock_in,
  input wire logic i_pll_tick,
  output logic o_hreadyout,
  output logic [31:0] o_hrdata,
  output logic o_hresp,
  output logic o_wave_out_a,
  output logic o_wave_out_b,
  output logic o_pins_owned
);
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_resetn);

  // registers seen by software
  logic [7:0] pwm_control_reg;
  logic [7:0] duty_a_low_byte;
  logic [7:0] duty_a_high_byte;
  logic [7:0] period_b_low_byte;
  logic [7:0] period_b_high_byte;
  // hidden low-byte buffers for the 16-bit modes
  logic [7:0] hidden_a_low;
  logic [7:0] hidden_b_low;
  // values in use for the running cycle
  logic [15:0] duty_a_act;
  logic [15:0] period_b_act;
  // bus data-phase state
  logic ph_valid;
  logic ph_write;
  logic [7:0] ph_addr;
  logic wr_en;
  logic wr_ctrl;
  logic [31:0] read_value;
  // mode decode
  pwd_pkg::pwd_mode_type mode;
  pwd_pkg::pwd_src_type src;
  logic mode_off;
  logic mode16;
  logic mode_sd;
  // clocking chain
  logic [3:0] xtal_div;
  logic ext_prev;
  logic src_tick;
  logic [5:0] presc;
  logic [5:0] div_last;
  logic count_tick;
  logic rz_phase;
  // counters and cycle control
  logic [15:0] counter;
  logic [7:0] cnt_b;
  logic [15:0] next_counter;
  logic [7:0] next_cnt_b;
  logic wrap;
  logic cycle_end;
  logic [15:0] cur_duty;
  logic [15:0] cur_period;
  logic next_wave_a;
  logic next_wave_b;
  logic sd_bit_a;
  logic sd_bit_b;

  assign mode = pwd_pkg::pwd_mode_type'(
    pwm_control_reg[pwd_pkg::MODE_POS +: 3]);
  assign src = pwd_pkg::pwd_src_type'(pwm_control_reg[pwd_pkg::SRC_POS +: 2]);
  assign mode_off = (mode == pwd_pkg::MODE_OFF)
    || (mode == pwd_pkg::MODE_RESERVED);
  assign mode16 = (mode == pwd_pkg::MODE_SINGLE)
    || (mode == pwd_pkg::MODE_TWIN16) || mode_sd;
  assign mode_sd = (mode == pwd_pkg::MODE_SD_NRZ)
    || (mode == pwd_pkg::MODE_SD_RZ);
  assign wr_en = ph_valid && ph_write;
  assign wr_ctrl = wr_en && (ph_addr == pwd_pkg::ADDR_CONTROL);

  // bus address phase capture; zero wait states, always okay
  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      ph_valid <= 1'b0;
      ph_write <= 1'b0;
      ph_addr <= 8'h00;
      o_hreadyout <= 1'b1;
      o_hresp <= pwd_pkg::HRESP_OKAY;
      o_hrdata <= 32'h0000_0000;
    end
    else
    begin
      ph_valid <= i_hsel && i_htrans[1] && i_hready;
      ph_write <= i_hwrite;
      ph_addr <= i_haddr;
      o_hreadyout <= 1'b1;
      o_hresp <= pwd_pkg::HRESP_OKAY;
      // read data sampled at the address phase, shown in the data phase
      if (i_hsel && i_htrans[1] && i_hready && !i_hwrite)
        o_hrdata <= read_value;
    end
  end

  // read mux; unmapped words read zero
  always_comb
  begin
    read_value = 32'h0000_0000;
    case (i_haddr)
      pwd_pkg::ADDR_CONTROL: read_value[7:0] = pwm_control_reg;
      pwd_pkg::ADDR_DUTY_A_LOW: read_value[7:0] = duty_a_low_byte;
      pwd_pkg::ADDR_DUTY_A_HIGH: read_value[7:0] = duty_a_high_byte;
      pwd_pkg::ADDR_PERIOD_B_LOW: read_value[7:0] = period_b_low_byte;
      pwd_pkg::ADDR_PERIOD_B_HIGH: read_value[7:0] = period_b_high_byte;
      pwd_pkg::ADDR_COUNTER: read_value[15:0] = counter;
      default: read_value = 32'h0000_0000;
    endcase
  end

  // register writes in the data phase
  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      pwm_control_reg <= pwd_pkg::CONTROL_RESET;
      duty_a_low_byte <= pwd_pkg::DATA_RESET;
      duty_a_high_byte <= pwd_pkg::DATA_RESET;
      period_b_low_byte <= pwd_pkg::DATA_RESET;
      period_b_high_byte <= pwd_pkg::DATA_RESET;
      hidden_a_low <= pwd_pkg::DATA_RESET;
      hidden_b_low <= pwd_pkg::DATA_RESET;
    end
    else if (wr_en)
    begin
      case (ph_addr)
        pwd_pkg::ADDR_CONTROL:
          pwm_control_reg <= i_hwdata[7:0] & pwd_pkg::CONTROL_WMASK;
        pwd_pkg::ADDR_DUTY_A_LOW:
        begin
          if (mode16)
            hidden_a_low <= i_hwdata[7:0];
          else
            duty_a_low_byte <= i_hwdata[7:0];
        end
        pwd_pkg::ADDR_PERIOD_B_LOW:
        begin
          if (mode16)
            hidden_b_low <= i_hwdata[7:0];
          else
            period_b_low_byte <= i_hwdata[7:0];
        end
        pwd_pkg::ADDR_DUTY_A_HIGH:
        begin
          duty_a_high_byte <= i_hwdata[7:0];
          if (mode16)
            duty_a_low_byte <= hidden_a_low;
        end
        pwd_pkg::ADDR_PERIOD_B_HIGH:
        begin
          period_b_high_byte <= i_hwdata[7:0];
          if (mode16)
            period_b_low_byte <= hidden_b_low;
        end
        default: ;
      endcase
    end
  end

  always_comb
  begin
    case (src)
      pwd_pkg::SRC_XTAL_DIV15:
        src_tick = i_xtal_tick && (xtal_div == pwd_pkg::XTAL_DIV_LAST);
      pwd_pkg::SRC_XTAL: src_tick = i_xtal_tick;
      pwd_pkg::SRC_EXTERNAL: src_tick = i_external_count_clock_in && !ext_prev;
      pwd_pkg::SRC_PLL: src_tick = i_pll_tick;
      default: src_tick = 1'b0;
    endcase
    case (pwm_control_reg[pwd_pkg::DIV_POS +: 2])
      2'h0: div_last = pwd_pkg::DIV_LAST_1;
      2'h1: div_last = pwd_pkg::DIV_LAST_4;
      2'h2: div_last = pwd_pkg::DIV_LAST_16;
      default: div_last = pwd_pkg::DIV_LAST_64;
    endcase
  end
  assign count_tick = src_tick && (presc == div_last);

  // prescaler, crystal /15 and the return-to-zero half-clock phase
  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      xtal_div <= 4'h0;
      ext_prev <= 1'b0;
      presc <= 6'h00;
      rz_phase <= 1'b0;
    end
    else
    begin
      ext_prev <= i_external_count_clock_in;
      if (i_xtal_tick)
        xtal_div <= (xtal_div == pwd_pkg::XTAL_DIV_LAST) ? 4'h0
          : xtal_div + 4'h1;
      if (wr_ctrl)
        presc <= 6'h00;
      else if (count_tick)
        presc <= 6'h00;
      else if (src_tick)
        presc <= presc + 6'h01;
      if (count_tick)
        rz_phase <= 1'b1;
      else if (src_tick && div_last != pwd_pkg::DIV_LAST_1
               && presc == (div_last >> 1))
        rz_phase <= 1'b0;
    end
  end

  // end of cycle per mode and next counter values
  always_comb
  begin
    wrap = 1'b1;
    next_cnt_b = 8'h00;
    case (mode)
      pwd_pkg::MODE_SINGLE: wrap = (counter == period_b_act - 16'h0001);
      pwd_pkg::MODE_TWIN8: wrap = (counter >= {8'h00, period_b_act[7:0]});
      pwd_pkg::MODE_TWIN16: wrap = (counter == pwd_pkg::FULL_LAST);
      pwd_pkg::MODE_SD_NRZ: wrap = (counter == pwd_pkg::FULL_LAST);
      pwd_pkg::MODE_SD_RZ: wrap = (counter == pwd_pkg::FULL_LAST);
      pwd_pkg::MODE_DUAL8:
      begin
        wrap = (counter >= {8'h00, period_b_act[7:0]});
        next_cnt_b = (cnt_b >= period_b_act[15:8]) ? 8'h00 : cnt_b + 8'h01;
      end
      default: wrap = 1'b1;
    endcase
    next_counter = wrap ? pwd_pkg::COUNT_RESET : counter + 16'h0001;
  end
  assign cycle_end = count_tick && wrap;
  // values that the new cycle will use
  assign cur_duty = cycle_end ? {duty_a_high_byte, duty_a_low_byte}
    : duty_a_act;
  assign cur_period = cycle_end ? {period_b_high_byte, period_b_low_byte}
    : period_b_act;

  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      counter <= pwd_pkg::COUNT_RESET;
      cnt_b <= 8'h00;
    end
    else if (wr_ctrl || mode_off)
    begin
      counter <= pwd_pkg::COUNT_RESET;
      cnt_b <= 8'h00;
    end
    else if (count_tick)
    begin
      counter <= next_counter;
      cnt_b <= next_cnt_b;
    end
  end

  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      duty_a_act <= 16'h0000;
      period_b_act <= 16'h0000;
    end
    else if (mode_off || cycle_end)
    begin
      duty_a_act <= {duty_a_high_byte, duty_a_low_byte};
      period_b_act <= {period_b_high_byte, period_b_low_byte};
    end
  end

  // two sigma-delta channels share the counter clock
  pwd_sd_channel #(.WIDTH(16)) u_sd_a (
    .i_clock(i_clock),
    .i_resetn(i_resetn),
    .i_clear(wr_ctrl),
    .i_enable(count_tick && mode_sd),
    .i_code(duty_a_act),
    .o_bit(sd_bit_a)
  );
  pwd_sd_channel #(.WIDTH(16)) u_sd_b (
    .i_clock(i_clock),
    .i_resetn(i_resetn),
    .i_clear(wr_ctrl),
    .i_enable(count_tick && mode_sd),
    .i_code(period_b_act),
    .o_bit(sd_bit_b)
  );

  // waveform decision per mode
  always_comb
  begin
    next_wave_a = o_wave_out_a;
    next_wave_b = o_wave_out_b;
    case (mode)
      pwd_pkg::MODE_SINGLE:
      begin
        if (count_tick)
          next_wave_a = next_counter < cur_duty;
        next_wave_b = 1'b0;
      end
      pwd_pkg::MODE_TWIN8:
      begin
        if (count_tick)
        begin
          next_wave_a = next_counter[7:0] < cur_duty[7:0];
          if (next_counter[7:0] == cur_period[15:8])
            next_wave_b = 1'b1;
          else if (next_counter[7:0] == cur_duty[15:8])
            next_wave_b = 1'b0;
        end
      end
      pwd_pkg::MODE_TWIN16:
      begin
        if (count_tick)
        begin
          next_wave_a = next_counter < cur_duty;
          next_wave_b = next_counter < cur_period;
        end
      end
      pwd_pkg::MODE_SD_NRZ:
      begin
        next_wave_a = sd_bit_a;
        next_wave_b = sd_bit_b;
      end
      pwd_pkg::MODE_DUAL8:
      begin
        if (count_tick)
        begin
          next_wave_a = next_counter[7:0] < cur_duty[7:0];
          next_wave_b = next_cnt_b < cur_duty[15:8];
        end
      end
      pwd_pkg::MODE_SD_RZ:
      begin
        next_wave_a = sd_bit_a && rz_phase;
        next_wave_b = sd_bit_b && rz_phase;
      end
      default:
      begin
        next_wave_a = 1'b0;
        next_wave_b = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_wave_out_a <= 1'b0;
      o_wave_out_b <= 1'b0;
      o_pins_owned <= 1'b0;
    end
    else
    begin
      o_wave_out_a <= mode_off ? 1'b0 : next_wave_a;
      o_wave_out_b <= mode_off ? 1'b0 : next_wave_b;
      o_pins_owned <= !mode_off;
    end
  end

  // single-cycle views used below
  sequence s_wrap16;
    count_tick && !wr_ctrl && counter == pwd_pkg::FULL_LAST;
  endsequence
  sequence s_restart;
    counter == pwd_pkg::COUNT_RESET;
  endsequence

  a_off_quiet: assert property (
    mode_off && $past(mode_off) |-> !o_wave_out_a && !o_wave_out_b
    && !o_pins_owned)
    else $error("waveform or pin ownership while disabled");
  a_ctrl_clear: assert property (
    wr_ctrl |=> counter == pwd_pkg::COUNT_RESET)
    else $error("control write did not clear counter");
  a_single_period: assert property (
    mode == pwd_pkg::MODE_SINGLE && count_tick && !wr_ctrl
    && counter == period_b_act - 16'h0001 |=> s_restart)
    else $error("single mode period not honoured");
  a_single_duty: assert property (
    mode == pwd_pkg::MODE_SINGLE && $past(mode == pwd_pkg::MODE_SINGLE)
    && $past(count_tick) && !$past(wr_ctrl)
    |-> o_wave_out_a == (counter < duty_a_act))
    else $error("single mode duty wrong");
  a_twin8_period: assert property (
    mode == pwd_pkg::MODE_TWIN8 && count_tick && !wr_ctrl
    && counter == {8'h00, period_b_act[7:0]} |=> s_restart)
    else $error("twin 8-bit period wrong");
  a_twin8_match: assert property (
    mode == pwd_pkg::MODE_TWIN8 && $past(mode == pwd_pkg::MODE_TWIN8)
    && $past(count_tick) && !$past(wr_ctrl)
    && counter[7:0] == period_b_act[15:8]
    |-> o_wave_out_b)
    else $error("out b not set at its match");
  a_twin16_wrap: assert property (
    (mode == pwd_pkg::MODE_TWIN16) and s_wrap16 |=> s_restart
    ##0 (o_wave_out_a == (duty_a_act != 16'h0000))
    ##0 (o_wave_out_b == (period_b_act != 16'h0000)))
    else $error("twin 16-bit rollover wrong");
  a_hold_commit: assert property (
    !mode_off && !cycle_end |=> $stable(duty_a_act) && $stable(period_b_act))
    else $error("values changed inside a cycle");
  a_rz_pulse: assert property (
    mode == pwd_pkg::MODE_SD_RZ && $past(mode == pwd_pkg::MODE_SD_RZ)
    && o_wave_out_b |-> $past(rz_phase))
    else $error("rz output high outside half clock");
  a_dual_period: assert property (
    mode == pwd_pkg::MODE_DUAL8 && count_tick && !wr_ctrl
    && cnt_b == period_b_act[15:8] |=> cnt_b == 8'h00)
    else $error("dual 8-bit second period wrong");
endmodule // pwd_top

// ---- pwd_pkg.sv ----
// constants, register map and mode types of the pwm / sigma-delta dac block
package pwd_pkg;
  // register byte addresses (one aligned 32-bit word each)
  localparam logic [7:0] ADDR_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_DUTY_A_LOW = 8'h04;
  localparam logic [7:0] ADDR_DUTY_A_HIGH = 8'h08;
  localparam logic [7:0] ADDR_PERIOD_B_LOW = 8'h0c;
  localparam logic [7:0] ADDR_PERIOD_B_HIGH = 8'h10;
  localparam logic [7:0] ADDR_COUNTER = 8'h14;
  // control register field positions
  localparam int MODE_POS = 4;
  localparam int DIV_POS = 2;
  localparam int SRC_POS = 0;
  // bit 7 is reserved and reads zero
  localparam logic [7:0] CONTROL_WMASK = 8'h7f;
  // values after reset
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  // crystal divided by 15: last state of a 0..14 count
  localparam logic [3:0] XTAL_DIV_LAST = 4'he;
  // last prescaler state for divide by 1, 4, 16 and 64
  localparam logic [5:0] DIV_LAST_1 = 6'h00;
  localparam logic [5:0] DIV_LAST_4 = 6'h03;
  localparam logic [5:0] DIV_LAST_16 = 6'h0f;
  localparam logic [5:0] DIV_LAST_64 = 6'h3f;
  // last count of a full 16-bit cycle
  localparam logic [15:0] FULL_LAST = 16'hffff;
  // half of full scale
  localparam logic [15:0] SD_HALF = 16'h8000;
  // bus response
  localparam logic HRESP_OKAY = 1'b0;
  // operating modes in field order
  typedef enum logic [2:0] {
    MODE_OFF,
    MODE_SINGLE,
    MODE_TWIN8,
    MODE_TWIN16,
    MODE_SD_NRZ,
    MODE_DUAL8,
    MODE_SD_RZ,
    MODE_RESERVED
  } pwd_mode_type;
  // counter clock sources in field order
  typedef enum logic [1:0] {
    SRC_XTAL_DIV15,
    SRC_XTAL,
    SRC_EXTERNAL,
    SRC_PLL
  } pwd_src_type;
endpackage

// ---- pwd_sd_channel.sv ----
// first-order sigma-delta channel: accumulator carry is the output bit
module pwd_sd_channel #(
  parameter int WIDTH = 16
) (
  input wire logic i_clock,
  input wire logic i_resetn,
  input wire logic i_clear,
  input wire logic i_enable,
  input wire logic [WIDTH-1:0] i_code,
  output logic o_bit
);
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_resetn);

  logic [WIDTH-1:0] acc; // running remainder
  logic [WIDTH:0] sum; // remainder plus code, carry on top
  // helpers for the window check
  logic [WIDTH-1:0] win_cnt;
  logic [WIDTH:0] ones;
  logic [WIDTH-1:0] code_q;
  logic code_ok;

  assign sum = {1'b0, acc} + {1'b0, i_code};

  // carry per step
  // one step per counter clock, carry marks a high clock
  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      acc <= '0;
      o_bit <= 1'b0;
    end
    else if (i_clear)
    begin
      acc <= '0;
      o_bit <= 1'b0;
    end
    else if (i_enable)
    begin
      acc <= sum[WIDTH-1:0];
      o_bit <= sum[WIDTH];
    end
  end

  // helper: count highs over each window of 2**WIDTH steps
  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      win_cnt <= '0;
      ones <= '0;
      code_q <= '0;
      code_ok <= 1'b0;
    end
    else
    begin
      code_q <= i_code;
      if (i_clear)
      begin
        win_cnt <= '0;
        ones <= '0;
        code_ok <= 1'b1;
      end
      else
      begin
        if (i_code != code_q)
          code_ok <= 1'b0;
        if (i_enable)
        begin
          win_cnt <= win_cnt + 1'b1;
          if (&win_cnt)
          begin
            ones <= '0;
            code_ok <= (i_code == code_q);
          end
          else
            ones <= ones + {{WIDTH{1'b0}}, sum[WIDTH]};
        end
      end
    end
  end

  a_window_ones: assert property (
    (i_enable && (&win_cnt) && code_ok && !i_clear && i_code == code_q)
    |-> (ones + {{WIDTH{1'b0}}, sum[WIDTH]}) == {1'b0, i_code})
    else $error("high count over a window differs from code");

  a_spread_highs: assert property (
    (i_enable && !i_clear && o_bit && i_code < pwd_pkg::SD_HALF
     && i_code == code_q) |=> !o_bit)
    else $error("highs bunched below half scale");
endmodule // pwd_sd_channel

// ---- pwd_tb.sv ----
// self-checking bench for the pwm / sigma-delta dac block
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  // one row: control value, settle and window cycles, expected counts
  typedef struct {
    logic [7:0] ctrl;
    int settle;
    int win;
    logic [31:0] ha;
    logic [31:0] hb;
    logic [31:0] ra;
    logic pins;
  } pwd_row_type;
  localparam int LIMIT = 90000;
  logic i_clock = 1'b0;
  logic i_resetn = 1'b0;
  logic i_hsel = 1'b0;
  logic [7:0] i_haddr = 8'h00;
  logic [1:0] i_htrans = 2'h0;
  logic i_hwrite = 1'b0;
  logic [2:0] i_hsize = 3'h2;
  logic [31:0] i_hwdata = 32'h0;
  logic i_xtal_tick = 1'b1;
  logic i_external_count_clock_in = 1'b0;
  logic i_pll_tick = 1'b0;
  logic o_hreadyout;
  logic [31:0] o_hrdata;
  logic o_hresp;
  logic o_wave_out_a;
  logic o_wave_out_b;
  logic o_pins_owned;
  logic [1:0] phase3 = 2'h0;
  int err_count = 0;
  int comparisons = 0;
  int cycles = 0;
  // rows: sources, dividers and modes over whole waveform periods, bar the 2000-cycle row
  pwd_row_type rows [13] = '{
    '{8'h21, 100, 600, 240, 420, 60, 1'b1},
    '{8'h20, 100, 600, 240, 420, 4, 1'b1},
    '{8'h22, 100, 600, 240, 420, 30, 1'b1},
    '{8'h23, 100, 600, 240, 420, 20, 1'b1},
    '{8'h25, 100, 600, 240, 420, 15, 1'b1},
    '{8'h55, 100, 600, 240, 200, 15, 1'b1},
    '{8'h11, 100, 1289, 516, 0, 1, 1'b1},
    // first count after a control write still shows the old level
    '{8'h31, 0, 2000, 515, 1288, 1, 1'b1},
    // one whole 16-bit cycle, rollover included
    '{8'h31, 100, 65536, 516, 1289, 1, 1'b1},
    // divide by 16 and by 64
    '{8'h29, 100, 640, 256, 448, 4, 1'b1},
    '{8'h2d, 200, 640, 256, 448, 1, 1'b1},
    '{8'h01, 100, 100, 0, 0, 0, 1'b0},
    '{8'h71, 100, 100, 0, 0, 0, 1'b0}};
  // device under test, hready looped back from the one slave
  pwd_top i_dut (
    .i_clock(i_clock),
    .i_resetn(i_resetn),
    .i_hsel(i_hsel),
    .i_haddr(i_haddr),
    .i_htrans(i_htrans),
    .i_hwrite(i_hwrite),
    .i_hsize(i_hsize),
    .i_hwdata(i_hwdata),
    .i_hready(o_hreadyout),
    .i_xtal_tick(i_xtal_tick),
    .i_external_count_clock_in(i_external_count_clock_in),
    .i_pll_tick(i_pll_tick),
    .o_hreadyout(o_hreadyout),
    .o_hrdata(o_hrdata),
    .o_hresp(o_hresp),
    .o_wave_out_a(o_wave_out_a),
    .o_wave_out_b(o_wave_out_b),
    .o_pins_owned(o_pins_owned)
  );
  // 100 mhz clock
  always #5 i_clock = ~i_clock;
  // source ticks: external rises every 2 cycles, pll every 3
  always @(posedge i_clock)
  begin
    i_external_count_clock_in <= ~i_external_count_clock_in;
    phase3 <= (phase3 == 2'h2) ? 2'h0 : phase3 + 2'h1;
    i_pll_tick <= (phase3 == 2'h2);
  end
  // hang guard
  always @(posedge i_clock)
  begin
    cycles <= cycles + 1;
    if (cycles == LIMIT)
    begin
      err_count++;
      print_verdict();
    end
  end
  // verdict and end of run
  task automatic print_verdict;
    if (err_count == 0 && comparisons > 0)
    begin
      $display("Test passed");
    end
    else
    begin
      $display("Test failed");
    end
    $finish;
  endtask
  // compare one value
  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // one single ahb-lite transfer, zero or more wait states
  task automatic bus(input logic wr, input logic [7:0] addr,
                     input logic [31:0] wdata, output logic [31:0] rdata);
    @(posedge i_clock);
    i_hsel <= 1'b1;
    i_htrans <= 2'h2;
    i_haddr <= addr;
    i_hwrite <= wr;
    do @(posedge i_clock); while (o_hreadyout !== 1'b1);
    i_hsel <= 1'b0;
    i_htrans <= 2'h0;
    i_hwdata <= wdata;
    do @(posedge i_clock); while (o_hreadyout !== 1'b1);
    rdata = o_hrdata;
  endtask
  // register write
  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    logic [31:0] unused;
    bus(1'b1, addr, {24'h0, data}, unused);
  endtask
  // register read and compare
  task automatic rd_check(input logic [7:0] addr, input logic [31:0] exp);
    logic [31:0] seen;
    bus(1'b0, addr, 32'h0, seen);
    check("register read", seen, exp);
  endtask
  // set a mode from disabled, then count highs of both pins and rises of pin a
  task automatic run_row(input pwd_row_type r);
    logic [31:0] ha;
    logic [31:0] hb;
    logic [31:0] ra;
    logic prev;
    ha = 32'h0;
    hb = 32'h0;
    ra = 32'h0;
    wr(pwd_pkg::ADDR_CONTROL, 8'h00);
    wr(pwd_pkg::ADDR_CONTROL, r.ctrl);
    repeat (r.settle) @(posedge i_clock);
    // level just before the window, so a window start is no false rise
    prev = o_wave_out_a;
    repeat (r.win)
    begin
      @(posedge i_clock);
      ha = ha + {31'h0, o_wave_out_a};
      hb = hb + {31'h0, o_wave_out_b};
      ra = ra + {31'h0, (o_wave_out_a === 1'b1 && prev === 1'b0)};
      prev = o_wave_out_a;
    end
    check("high count a", ha, r.ha);
    check("high count b", hb, r.hb);
    check("rise count a", ra, r.ra);
    check("pins owned", {31'h0, o_pins_owned}, {31'h0, r.pins});
  endtask
  // main sequence
  initial
  begin
    repeat (16) @(posedge i_clock);
    i_resetn <= 1'b1;
    check("hreadyout", {31'h0, o_hreadyout}, 32'h1);
    check("hresp", {31'h0, o_hresp}, 32'h0);
    check("pins after reset", {31'h0, o_pins_owned}, 32'h0);
    for (int a = 0; a <= 24; a += 4)
    begin
      rd_check(8'(a), 32'h0);
    end
    // data written while disabled goes straight to the active values
    wr(pwd_pkg::ADDR_DUTY_A_LOW, 8'h04);
    wr(pwd_pkg::ADDR_DUTY_A_HIGH, 8'h02);
    wr(pwd_pkg::ADDR_PERIOD_B_LOW, 8'h09);
    wr(pwd_pkg::ADDR_PERIOD_B_HIGH, 8'h05);
    foreach (rows[i])
    begin
      run_row(rows[i]);
    end
    wr(pwd_pkg::ADDR_CONTROL, 8'h11);
    wr(pwd_pkg::ADDR_DUTY_A_LOW, 8'h33);
    rd_check(pwd_pkg::ADDR_DUTY_A_LOW, 32'h04);
    wr(pwd_pkg::ADDR_DUTY_A_HIGH, 8'h02);
    rd_check(pwd_pkg::ADDR_DUTY_A_LOW, 32'h33);
    wr(pwd_pkg::ADDR_CONTROL, 8'h24);
    repeat (300) @(posedge i_clock);
    wr(pwd_pkg::ADDR_CONTROL, 8'h24);
    rd_check(pwd_pkg::ADDR_COUNTER, 32'h0);
    wr(pwd_pkg::ADDR_CONTROL, 8'hff);
    rd_check(pwd_pkg::ADDR_CONTROL, 32'h7f);
    check("pins reserved", {31'h0, o_pins_owned}, 32'h0);
    // unmapped write is ignored
    wr(8'h18, 8'ha5);
    rd_check(8'h18, 32'h0);
    // return-to-zero pulses with divide by four
    // full-width codes, so no low-bit padding is asked
    wr(pwd_pkg::ADDR_CONTROL, 8'h00);
    wr(pwd_pkg::ADDR_DUTY_A_LOW, 8'h00);
    wr(pwd_pkg::ADDR_DUTY_A_HIGH, 8'h40);
    wr(pwd_pkg::ADDR_PERIOD_B_LOW, 8'h00);
    wr(pwd_pkg::ADDR_PERIOD_B_HIGH, 8'h80);
    run_row('{8'h65, 100, 4096, 512, 1024, 256, 1'b1});
    // nrz dac: quarter and half scale over whole sequences
    run_row('{8'h41, 100, 4096, 1024, 2048, 1024, 1'b1});
    print_verdict();
  end
endmodule // tb
